// [rtl/sdcm_pkg.sv]
/*
  Shared constants and carrier types for the synchronous DRAM device model:
  array geometry, command codes, mode register field positions and the
  bank state enumeration.
  Assumes one clock domain and that every file imports the whole package.
*/
package sdcm_pkg;

  // Array geometry
  localparam int NUM_BANKS = 4;
  localparam int NUM_ROWS = 4096;
  localparam int NUM_COLS = 256;
  localparam int DATA_W = 16;
  localparam int ROW_W = 12;
  localparam int COL_W = 8;

  // Address bit that carries the precharge / auto precharge flag
  localparam int PRECHARGE_FLAG_POS = 10;

  // Mode register layout
  localparam int MODE_W = 14;
  localparam int BL_LSB = 0;
  localparam int ORDER_POS = 3;
  localparam int RL_LSB = 4;
  localparam int OPMODE_LSB = 7;
  localparam int WRITE_BURST_POS = 9;
  localparam int MODE_DATA_W = 12;

  // Reset values
  localparam logic [MODE_W-1:0] MODE_RESET = 14'h0000;
  localparam logic [3:0] COUNT_RESET = 4'h0;

  // Data FIFO depth
  localparam int FIFO_DEPTH = 16;

  // Command code {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    CMD_MODE_LOAD = 4'b0000,
    CMD_REFRESH = 4'b0001,
    CMD_PRECHARGE = 4'b0010,
    CMD_ACTIVE = 4'b0011,
    CMD_WRITE = 4'b0100,
    CMD_READ = 4'b0101,
    CMD_TERMINATE = 4'b0110,
    CMD_NOP = 4'b0111
  } sdcm_cmd_t;

  // Captured command bundle
  typedef struct packed {
    logic [3:0] cmd;
    logic [1:0] bank;
    logic [ROW_W-1:0] addr;
  } sdcm_req_t;

  // Per-bank state
  typedef enum logic [0:0] {
    BANK_IDLE = 1'b0,
    BANK_OPEN = 1'b1
  } sdcm_bank_t;

  // Burst engine state
  typedef enum logic [1:0] {
    BURST_NONE = 2'b00,
    BURST_READ = 2'b01,
    BURST_WRITE = 2'b10
  } sdcm_burst_t;

endpackage : sdcm_pkg

// [rtl/sdcm_fifo.sv]
/*
  Parameterised valid/ready FIFO for read data leaving the device array.
  Assumes a single clock and an active-low asynchronous reset.
*/
module sdcm_fifo
  import sdcm_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH]; // Storage
  logic [AW:0] wr_ptr; // Write pointer with wrap bit
  logic [AW:0] rd_ptr; // Read pointer with wrap bit
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic push;
  logic pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer advance
  always_comb
  begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  // Pointer registers
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage write, no reset needed
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

endmodule : sdcm_fifo

// [rtl/sdcm_device.sv]
/*
  Device side of a four-bank synchronous DRAM: command decode, bank and
  row/column addressing, precharge handling, mode register and bursts.
  Assumes the controller keeps its own duties (power-up wait, refreshes,
  mode load spacing) and that all pins arrive synchronous to clock.
*/
// Overview of operation
// - All inputs captured on rising clock edge
// - Four banks of 4096 rows x 256 columns
// - Bank-select lines choose the addressed bank
// - Bank-select picks standard or extended mode register
// - ACTIVE takes twelve address lines as row
// - Low eight bits column, bit ten auto-precharge
// - PRECHARGE bit ten high closes all banks
// - Mode load takes contents from address lines
// - Mode register undefined until controller loads; reset here clears it to zero
// - Bits 0-2 burst length, bit 3 order
// - Bits 4-6 latency, 7-8 mode, 9 write
// - Mode register holds until rewritten
// - Burst lengths 1,2,4,8 wrap in aligned block
// - Read data valid latency edges after READ; only latency two and three give data here
// - Write-burst bit forces single-location writes
module sdcm_device
  import sdcm_pkg::*;
#(
  parameter int BANK_ROWS = NUM_ROWS,
  parameter int BANK_COLS = NUM_COLS
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic [ROW_W-1:0] row_col_address_lines,
  input wire logic [DATA_W-1:0] data_bus_lines_in,
  output logic [DATA_W-1:0] data_bus_lines_out,
  output logic data_bus_lines_oe,
  output logic [MODE_W-1:0] burst_and_latency_config,
  output logic [MODE_W-1:0] extended_config,
  output logic [NUM_BANKS-1:0] bank_open
);

  sdcm_req_t req; // Command bundle seen at this edge
  logic [MODE_W-1:0] next_mode;
  logic [MODE_W-1:0] next_ext;
  sdcm_bank_t bank_st [NUM_BANKS];
  sdcm_bank_t next_bank_st [NUM_BANKS];
  logic [ROW_W-1:0] open_row [NUM_BANKS];
  logic [ROW_W-1:0] next_open_row [NUM_BANKS];
  logic [DATA_W-1:0] mem [NUM_BANKS*BANK_ROWS*BANK_COLS]; // Array storage
  sdcm_burst_t burst;
  sdcm_burst_t next_burst;
  logic [1:0] burst_bank;
  logic [1:0] next_burst_bank;
  logic [COL_W-1:0] burst_col;
  logic [COL_W-1:0] next_burst_col;
  logic [3:0] burst_idx;
  logic [3:0] next_burst_idx;
  logic [3:0] burst_len;
  logic [3:0] next_burst_len;
  logic burst_ap;
  logic next_burst_ap;
  logic rd_late; // Word of a latency-three read waits one edge
  logic next_rd_late;
  logic [DATA_W-1:0] arr_word; // Array word at the current beat
  logic [DATA_W-1:0] rd_word; // Array word one edge later
  logic [DATA_W-1:0] rd_in; // Word handed to the queue
  logic rd_valid;
  logic fifo_valid;
  logic [DATA_W-1:0] fifo_data;
  logic [COL_W-1:0] cur_col;
  logic [3:0] prog_len;
  logic [3:0] wr_len;
  logic [2:0] rl;

  // Decode burst length field into word count
  function automatic logic [3:0] bl_decode(input logic [2:0] f);
    unique case (f)
      3'h0: bl_decode = 4'h1;
      3'h1: bl_decode = 4'h2;
      3'h2: bl_decode = 4'h4;
      3'h3: bl_decode = 4'h8;
      default: bl_decode = 4'h1;
    endcase
  endfunction : bl_decode

  // Column at position idx of a burst, wrapping in aligned block
  function automatic logic [COL_W-1:0] burst_column(input logic [COL_W-1:0] start, input logic [3:0] idx,
                                                    input logic [3:0] len, input logic interleave);
    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] offs;
    mask = COL_W'(len) - 1'b1;
    offs = interleave ? ((start & mask) ^ COL_W'(idx)) : ((start + COL_W'(idx)) & mask);
    burst_column = (start & ~mask) | (offs & mask);
  endfunction : burst_column

  // Flat array index from bank, row, column
  function automatic int arr_index(input logic [1:0] b, input logic [ROW_W-1:0] r, input logic [COL_W-1:0] c);
    arr_index = (int'(b) * BANK_ROWS + int'(r)) * BANK_COLS + int'(c);
  endfunction : arr_index

  // Pins are taken as they stand at the rising edge
  assign req.cmd = {cs_n, ras_n, cas_n, we_n};
  assign req.bank = {bank_select_high, bank_select_low};
  assign req.addr = row_col_address_lines;

  // Mode fields
  assign prog_len = bl_decode(burst_and_latency_config[BL_LSB+:3]);
  assign wr_len = burst_and_latency_config[WRITE_BURST_POS] ? 4'h1 : prog_len;
  assign rl = burst_and_latency_config[RL_LSB+:3];
  assign cur_col = burst_column(burst_col, burst_idx, burst_len, burst_and_latency_config[ORDER_POS]);

  // Mode registers: written only by mode load, held otherwise
  always_comb
  begin
    next_mode = burst_and_latency_config;
    next_ext = extended_config;
    if (req.cmd == CMD_MODE_LOAD)
    begin
      if (req.bank == 2'b10)
      begin
        next_ext = {2'b10, req.addr};
      end
      else
      begin
        next_mode = {req.bank, req.addr};
      end
    end
  end

  // Bank state and burst engine
  always_comb
  begin
    next_burst = burst;
    next_burst_bank = burst_bank;
    next_burst_col = burst_col;
    next_burst_idx = burst_idx;
    next_burst_len = burst_len;
    next_burst_ap = burst_ap;
    for (int i = 0; i < NUM_BANKS; i++)
    begin
      next_bank_st[i] = bank_st[i];
      next_open_row[i] = open_row[i];
    end
    // Advance a running burst
    if (burst != BURST_NONE)
    begin
      if (burst_idx + 1'b1 >= burst_len)
      begin
        next_burst = BURST_NONE;
        if (burst_ap)
        begin
          next_bank_st[burst_bank] = BANK_IDLE;
        end
      end
      else
      begin
        next_burst_idx = burst_idx + 1'b1;
      end
    end
    unique case (req.cmd)
      CMD_ACTIVE:
      begin
        next_bank_st[req.bank] = BANK_OPEN;
        next_open_row[req.bank] = req.addr;
      end
      CMD_READ, CMD_WRITE:
      begin
        next_burst = (req.cmd == CMD_READ) ? BURST_READ : BURST_WRITE;
        next_burst_bank = req.bank;
        next_burst_col = req.addr[COL_W-1:0];
        next_burst_ap = req.addr[PRECHARGE_FLAG_POS];
        next_burst_idx = COUNT_RESET;
        next_burst_len = (req.cmd == CMD_READ) ? prog_len : wr_len;
      end
      CMD_PRECHARGE:
      begin
        for (int i = 0; i < NUM_BANKS; i++)
        begin
          if (req.addr[PRECHARGE_FLAG_POS] || (req.bank == 2'(i)))
          begin
            next_bank_st[i] = BANK_IDLE;
          end
        end
      end
      CMD_TERMINATE:
      begin
        next_burst = BURST_NONE;
      end
      default:
      begin
        next_burst = next_burst;
      end
    endcase
  end

  // Late launch flag: latency three delays the push by one edge so the
  // first word reaches the pins exactly read_latency edges after READ
  always_comb
  begin
    next_rd_late = (burst == BURST_READ) && (rl == 3'h3);
  end

  // State registers
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      burst_and_latency_config <= MODE_RESET;
      extended_config <= MODE_RESET;
      burst <= BURST_NONE;
      burst_bank <= '0;
      burst_col <= '0;
      burst_idx <= COUNT_RESET;
      burst_len <= COUNT_RESET;
      burst_ap <= 1'b0;
      rd_late <= 1'b0;
      for (int i = 0; i < NUM_BANKS; i++)
      begin
        bank_st[i] <= BANK_IDLE;
        open_row[i] <= '0;
      end
    end
    else
    begin
      burst_and_latency_config <= next_mode;
      extended_config <= next_ext;
      burst <= next_burst;
      burst_bank <= next_burst_bank;
      burst_col <= next_burst_col;
      burst_idx <= next_burst_idx;
      burst_len <= next_burst_len;
      burst_ap <= next_burst_ap;
      rd_late <= next_rd_late;
      for (int i = 0; i < NUM_BANKS; i++)
      begin
        bank_st[i] <= next_bank_st[i];
        open_row[i] <= next_open_row[i];
      end
    end
  end

  // Array word at the beat the burst engine points to
  assign arr_word = mem[arr_index(burst_bank, open_row[burst_bank], cur_col)];

  // Array access: write data taken at the edge of each write beat
  always_ff @(posedge clock)
  begin
    if (burst == BURST_WRITE)
    begin
      mem[arr_index(burst_bank, open_row[burst_bank], cur_col)] <= data_bus_lines_in;
    end
    rd_word <= arr_word;
  end

  // Latency two pushes the array word at once, latency three the held one;
  // other latency codes push nothing, so such a read gives no data
  assign rd_valid = ((burst == BURST_READ) && (rl == 3'h2)) || rd_late;
  assign rd_in = rd_late ? rd_word : arr_word;

  // Read words queue so latency alignment never drops a word
  sdcm_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rd_fifo (
    .clock(clock),
    .nrst(nrst),
    .in_valid(rd_valid),
    .in_ready(),
    .in_data(rd_in),
    .out_valid(fifo_valid),
    .out_ready(1'b1),
    .out_data(fifo_data)
  );

  // Pins show the queue head while a word is due and zero otherwise;
  // enable and data rise together one edge before the word is sampled
  assign data_bus_lines_oe = fifo_valid;
  assign data_bus_lines_out = fifo_valid ? fifo_data : '0;

  // Bank open flags for observation
  always_comb
  begin
    for (int i = 0; i < NUM_BANKS; i++)
    begin
      bank_open[i] = (bank_st[i] == BANK_OPEN);
    end
  end

endmodule : sdcm_device

// [dv/sdcm_chk.sv]
/* Port checker for the DRAM device: mode loads, bank state, read launch.
   Assumes it is bound into every sdcm_device instance. */
module sdcm_chk
  import sdcm_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic [ROW_W-1:0] row_col_address_lines,
  input wire logic data_bus_lines_oe,
  input wire logic [MODE_W-1:0] burst_and_latency_config,
  input wire logic [MODE_W-1:0] extended_config,
  input wire logic [NUM_BANKS-1:0] bank_open
);
  timeunit 1ns;
  timeprecision 100ps;
  // Decoded pins
  wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  wire [1:0] bk = {bank_select_high, bank_select_low};
  wire [MODE_W-1:0] op = {bk, row_col_address_lines};
  wire ld = cmd == CMD_MODE_LOAD;
  wire ext = ld && bk == 2'b10;
  wire a10 = row_col_address_lines[PRECHARGE_FLAG_POS];
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  std_load_a: assert property (ld && !ext |=> burst_and_latency_config == $past(op))
    else $error("mode load lost");
  ext_load_a: assert property (ext |=> extended_config == $past(op))
    else $error("extended load lost");
  mode_hold_a: assert property (!(ld && !ext) |=> $stable(burst_and_latency_config))
    else $error("mode changed");
  ext_hold_a: assert property (!ext |=> $stable(extended_config))
    else $error("extended changed");
  row_open_a: assert property (cmd == CMD_ACTIVE |=> bank_open[$past(bk)])
    else $error("row not open");
  close_all_a: assert property (cmd == CMD_PRECHARGE && a10 |=> bank_open == 4'h0)
    else $error("banks left open");
  close_one_a: assert property (cmd == CMD_PRECHARGE && !a10 |=> !bank_open[$past(bk)])
    else $error("bank left open");
  rd_lat2_a: assert property (cmd == CMD_READ && burst_and_latency_config[RL_LSB+:3] == 3'h2
    |-> ##2 data_bus_lines_oe) else $error("latency two data not on time");
  rd_lat3_a: assert property (cmd == CMD_READ && burst_and_latency_config[RL_LSB+:3] == 3'h3
    |-> ##3 data_bus_lines_oe) else $error("latency three data not on time");
  // Main scenarios
  cover property (ld);
  cover property (cmd == CMD_READ);
  cover property (cmd == CMD_PRECHARGE && a10);
  cover property (cmd == CMD_WRITE);
endmodule : sdcm_chk
bind sdcm_device sdcm_chk chk_u (
  .clock(clock),
  .nrst(nrst),
  .cs_n(cs_n),
  .ras_n(ras_n),
  .cas_n(cas_n),
  .we_n(we_n),
  .bank_select_low(bank_select_low),
  .bank_select_high(bank_select_high),
  .row_col_address_lines(row_col_address_lines),
  .data_bus_lines_oe(data_bus_lines_oe),
  .burst_and_latency_config(burst_and_latency_config),
  .extended_config(extended_config),
  .bank_open(bank_open)
);

// [dv/sdcm_ctrl.sv]
/* Controller partner: drives command, address and write data pins.
   Assumes the device samples every pin at the rising clock edge. */
module sdcm_ctrl
  import sdcm_pkg::*;
#(
  parameter int WAIT_CYC = 4000, // Start-up wait: 100 us at 25 ns per cycle
  parameter int MRD_CYC = 2 // Wait after a mode load, plain default
)
(
  input wire logic clock,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic bank_select_low,
  output logic bank_select_high,
  output logic [ROW_W-1:0] row_col_address_lines,
  output logic [DATA_W-1:0] data_bus_lines_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle pins at time zero
  initial
  begin
    {cs_n, ras_n, cas_n, we_n} = CMD_NOP;
    {bank_select_high, bank_select_low} = 2'b00;
    row_col_address_lines = 12'h000;
    data_bus_lines_in = 16'h0000;
  end
  // One command at one edge, then NOP and flipped address
  task automatic send(input sdcm_cmd_t k, input logic [1:0] b, input logic [ROW_W-1:0] a);
    @(posedge clock);
    {cs_n, ras_n, cas_n, we_n} <= k;
    {bank_select_high, bank_select_low} <= b;
    row_col_address_lines <= a;
    @(posedge clock);
    {cs_n, ras_n, cas_n, we_n} <= CMD_NOP;
    row_col_address_lines <= ~a;
  endtask : send
  // Single write, data held over three edges, then flipped
  task automatic put(input logic [1:0] b, input logic [7:0] c, input logic [DATA_W-1:0] d);
    @(posedge clock);
    data_bus_lines_in <= d;
    send(CMD_WRITE, b, {4'h0, c});
    @(posedge clock);
    data_bus_lines_in <= ~d;
  endtask : put
  // Write burst: one data word per beat, beat j carrying d | j
  task automatic put_burst(input logic [1:0] b, input logic [7:0] c, input int n, input logic [DATA_W-1:0] d);
    send(CMD_WRITE, b, {4'h0, c});
    for (int j = 0; j < n; j++)
    begin
      data_bus_lines_in <= d | DATA_W'(j);
      @(posedge clock);
    end
  endtask : put_burst
  // Mode load while idle, then a wait before the next command
  task automatic load(input logic [MODE_W-1:0] m);
    send(CMD_MODE_LOAD, m[13:12], m[11:0]);
    repeat (MRD_CYC) @(posedge clock);
  endtask : load
  // Power-up: NOP wait, precharge all, two refreshes, mode load
  task automatic init(input logic [MODE_W-1:0] m);
    repeat (WAIT_CYC) @(posedge clock);
    send(CMD_PRECHARGE, 2'b00, 12'h400);
    repeat (2) send(CMD_REFRESH, 2'b00, 12'h000);
    load(m);
  endtask : init
endmodule : sdcm_ctrl

// [dv/tb_top.sv]
/* Bench for the DRAM device: power-up, mode loads, bank state, reads.
   Assumes the controller partner and the bound checker. */
module tb_top
  import sdcm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high;
  logic [ROW_W-1:0] row_col_address_lines;
  logic [DATA_W-1:0] data_bus_lines_in, data_bus_lines_out;
  logic data_bus_lines_oe;
  logic [MODE_W-1:0] burst_and_latency_config, extended_config;
  logic [NUM_BANKS-1:0] bank_open;
  int fail_count = 0;
  int samples_checked = 0;
  // 40 MHz clock
  always #12.5 clock = ~clock;
  sdcm_device #(
    .BANK_ROWS(16)
  ) dut_u (
    .clock(clock),
    .nrst(nrst),
    .cs_n(cs_n),
    .ras_n(ras_n),
    .cas_n(cas_n),
    .we_n(we_n),
    .bank_select_low(bank_select_low),
    .bank_select_high(bank_select_high),
    .row_col_address_lines(row_col_address_lines),
    .data_bus_lines_in(data_bus_lines_in),
    .data_bus_lines_out(data_bus_lines_out),
    .data_bus_lines_oe(data_bus_lines_oe),
    .burst_and_latency_config(burst_and_latency_config),
    .extended_config(extended_config),
    .bank_open(bank_open)
  );
  sdcm_ctrl ctrl_u (
    .clock(clock),
    .cs_n(cs_n),
    .ras_n(ras_n),
    .cas_n(cas_n),
    .we_n(we_n),
    .bank_select_low(bank_select_low),
    .bank_select_high(bank_select_high),
    .row_col_address_lines(row_col_address_lines),
    .data_bus_lines_in(data_bus_lines_in)
  );
  // Mode word with zero reserved and normal operating mode
  function automatic logic [MODE_W-1:0] mode_word(input logic [2:0] bf, input logic il,
                                                  input logic [2:0] rl, input logic wb);
    return {4'h0, wb, 2'b00, rl, il, bf};
  endfunction : mode_word
  // Column of beat i within the aligned block
  function automatic logic [7:0] order_col(input logic [7:0] s, input int i, input logic [2:0] bf,
                                           input logic il);
    logic [7:0] m;
    m = (8'h01 << bf) - 8'h01;
    return (s & ~m) | ((il ? s ^ 8'(i) : s + 8'(i)) & m);
  endfunction : order_col
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    samples_checked++;
    if (seen !== want)
    begin
      fail_count++;
      $display("BAD %0t %s %h %h", $time, what, seen, want);
    end
  endtask : check
  // Verdict
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude
  // Main sequence
  initial
  begin
    logic [MODE_W-1:0] m;
    logic [1:0] b;
    logic [2:0] bf;
    logic [7:0] s;
    logic il;
    logic [DATA_W-1:0] q[$];
    void'($urandom(52));
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    m = mode_word(3'd3, 1'b0, 3'd2, 1'b1);
    ctrl_u.init(m);
    @(negedge clock);
    check(16'(burst_and_latency_config), 16'(m), "mode");
    ctrl_u.load(14'h2020);
    @(negedge clock);
    check(16'(extended_config), 16'h2020, "ext");
    check(16'(burst_and_latency_config), 16'(m), "kept");
    $display("power-up test done");
    for (int i = 0; i < 8; i++)
    begin
      b = 2'($urandom);
      ctrl_u.send(CMD_ACTIVE, b, {8'h00, 4'($urandom)});
      @(negedge clock);
      check(16'(bank_open[b]), 16'h0001, "open");
      ctrl_u.send(CMD_PRECHARGE, b, {1'b0, i[0], 10'h000});
      @(negedge clock);
      check(16'(bank_open), 16'h0000, "close");
    end
    $display("bank test done");
    ctrl_u.send(CMD_ACTIVE, 2'b01, 12'h003);
    for (int c = 0; c < 8; c++)
      ctrl_u.put(2'b01, 8'(c), 16'hC300 | 16'(c));
    for (int i = 0; i < 12; i++)
    begin
      bf = 3'(i % 4);
      il = 1'($urandom);
      s = 8'($urandom % 8);
      ctrl_u.send(CMD_PRECHARGE, 2'b00, 12'h400);
      ctrl_u.load(mode_word(bf, il, 3'd2 + 3'($urandom % 2), 1'b1));
      ctrl_u.send(CMD_ACTIVE, 2'b01, 12'h003);
      ctrl_u.send(CMD_READ, 2'b01, {1'b0, i[0], 2'b00, s});
      q.delete();
      repeat (20)
      begin
        @(negedge clock);
        if (data_bus_lines_oe === 1'b1)
          q.push_back(data_bus_lines_out);
      end
      check(16'(q.size()), 16'h0001 << bf, "count");
      foreach (q[k])
        check(q[k], 16'hC300 | 16'(order_col(s, k, bf, il)), "word");
      check(16'(bank_open[1]), 16'(!i[0]), "auto");
    end
    $display("read test done");
    ctrl_u.send(CMD_PRECHARGE, 2'b00, 12'h400);
    ctrl_u.load(mode_word(3'h2, 1'b0, 3'h3, 1'b0));
    ctrl_u.send(CMD_ACTIVE, 2'b10, 12'h005);
    ctrl_u.put_burst(2'b10, 8'h04, 4, 16'hA500);
    ctrl_u.send(CMD_READ, 2'b10, 12'h004);
    q.delete();
    repeat (12)
    begin
      @(negedge clock);
      if (data_bus_lines_oe === 1'b1)
        q.push_back(data_bus_lines_out);
    end
    check(16'(q.size()), 16'h0004, "burst count");
    foreach (q[k])
      check(q[k], 16'hA500 | 16'(k), "burst word");
    $display("write burst test done");
    conclude();
  end
endmodule : tb_top
